// ### verilog/smbus_id_pkg.sv
package smbus_id_pkg;

  // ----------------------------------------
  // byte indices of the register window
  // ----------------------------------------
  localparam logic [7:0] IDX_RESERVED = 8'h04;
  localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
  localparam logic [7:0] IDX_DEVICE_TYPE = 8'h06;
  localparam logic [7:0] IDX_READ_LENGTH = 8'h07;

  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam logic [7:0] RESERVED_VALUE = 8'hff;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  localparam int READ_LENGTH_WIDTH = 5;
  localparam int READ_LENGTH_LSB = 0;
  localparam logic [4:0] READ_LENGTH_RESET = 5'h08;
  localparam int REVISION_LSB = 4;
  localparam int MAKER_CODE_LSB = 0;
  localparam int PART_CLASS_LSB = 6;
  localparam int PART_CODE_LSB = 0;

  // ----------------------------------------
  // serial framing
  // ----------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [7:0] INDEX_STEP = 8'h01;

  typedef enum {
    phase_idle,
    phase_rx,
    phase_ack_out,
    phase_tx,
    phase_ack_in
  } phase_type;

  typedef enum {
    role_addr,
    role_index,
    role_count,
    role_data
  } role_type;

endpackage

// ### verilog/id_reg_bank.sv
module id_reg_bank
  import smbus_id_pkg::*;
#(
  parameter logic [3:0] REVISION_CODE = 4'h3,  // arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'ha,     // arbitrary value
  parameter logic [1:0] PART_CLASS = 2'h2,     // arbitrary value
  parameter logic [5:0] PART_CODE = 6'h2a      // arbitrary value
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [7:0] wr_index,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_index,
  output logic [7:0] rd_data,
  output logic [4:0] read_length
);

  logic [4:0] read_length_reg;
  logic [4:0] read_length_next;

  // only the count byte accepts data; every other index swallows the write
  function automatic logic is_writable(input logic [7:0] index);
    is_writable = (index == IDX_READ_LENGTH);
  endfunction

  // ----------------------------------------
  // count register
  // ----------------------------------------
  // reserved and identification bytes have no storage, so writes vanish
  always_comb begin
    read_length_next = read_length_reg;
    if (wr_en && is_writable(wr_index)) begin
      read_length_next = wr_data[READ_LENGTH_LSB +: READ_LENGTH_WIDTH];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      read_length_reg <= READ_LENGTH_RESET;
    end else begin
      read_length_reg <= read_length_next;
    end
  end

  assign read_length = read_length_reg;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // indices outside the window answer zero rather than floating
  always_comb begin
    rd_data = UNMAPPED_VALUE;
    if (rd_index == IDX_RESERVED) begin
      rd_data = RESERVED_VALUE;
    end else if (rd_index == IDX_REV_VENDOR) begin
      rd_data = 8'h00;
      rd_data[REVISION_LSB +: 4] = REVISION_CODE;
      rd_data[MAKER_CODE_LSB +: 4] = MAKER_CODE;
    end else if (rd_index == IDX_DEVICE_TYPE) begin
      rd_data = 8'h00;
      rd_data[PART_CLASS_LSB +: 2] = PART_CLASS;
      rd_data[PART_CODE_LSB +: 6] = PART_CODE;
    end else if (is_writable(rd_index)) begin
      rd_data = 8'h00;
      rd_data[READ_LENGTH_LSB +: READ_LENGTH_WIDTH] = read_length_reg;
    end
  end

endmodule

// ### verilog/smbus_id_regs.sv
module smbus_id_regs
  import smbus_id_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h50,
  parameter logic [3:0] REVISION_CODE = 4'h3,  // arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'ha,     // arbitrary value
  parameter logic [1:0] PART_CLASS = 2'h2,     // arbitrary value
  parameter logic [5:0] PART_CODE = 6'h2a      // arbitrary value
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [4:0] read_length
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // the general call and start byte addresses cannot name this slave
  if (SLAVE_ADDR == 7'h00 || SLAVE_ADDR == 7'h01) begin : bad_addr
    $error("slave address collides with a reserved bus address");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;

  // third stage only feeds edge detection, first stage feeds nothing else
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;

  // start and stop are data edges while the clock stays high
  assign scl_rise = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall = ~scl_sync_reg & scl_prev_reg;
  assign bus_start = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign bus_stop = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  logic wr_en;
  logic [7:0] rd_data;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] index_reg, index_next;

  id_reg_bank #(
    .REVISION_CODE(REVISION_CODE),
    .MAKER_CODE(MAKER_CODE),
    .PART_CLASS(PART_CLASS),
    .PART_CODE(PART_CODE)
  ) bank (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_en(wr_en),
    .wr_index(index_reg),
    .wr_data(shift_reg),
    .rd_index(index_reg),
    .rd_data(rd_data),
    .read_length(read_length)
  );

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  phase_type phase_reg, phase_next;
  role_type role_reg, role_next;
  logic [3:0] count_reg, count_next;
  logic read_mode_reg, read_mode_next;
  logic acked_reg, acked_next;
  logic oe_reg, oe_next;
  logic [7:0] tx_byte;

  // data changes only after a clock fall, so setup and hold come from the low phase
  always_comb begin
    phase_next = phase_reg;
    role_next = role_reg;
    shift_next = shift_reg;
    index_next = index_reg;
    count_next = count_reg;
    read_mode_next = read_mode_reg;
    acked_next = acked_reg;
    oe_next = oe_reg;
    wr_en = 1'b0;
    tx_byte = rd_data;
    if (bus_start) begin
      // a repeated start keeps the index written just before it
      phase_next = phase_rx;
      role_next = role_addr;
      count_next = 4'h0;
      read_mode_next = 1'b0;
      oe_next = 1'b0;
    end else if (bus_stop) begin
      phase_next = phase_idle;
      oe_next = 1'b0;
    end else begin
      case (phase_reg)
        phase_rx: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_sync_reg};
            count_next = count_reg + 4'h1;
          end else if (scl_fall && count_reg == BITS_PER_BYTE) begin
            count_next = 4'h0;
            oe_next = 1'b1;
            phase_next = phase_ack_out;
            case (role_reg)
              role_addr: begin
                if (shift_reg[7:1] == SLAVE_ADDR) begin
                  read_mode_next = shift_reg[0];
                  role_next = shift_reg[0] ? role_count : role_index;
                end else begin
                  oe_next = 1'b0;
                  phase_next = phase_idle;
                end
              end
              role_index: begin
                index_next = shift_reg;
                role_next = role_count;
              end
              role_count: begin
                // the host's byte count is acknowledged but not used
                role_next = role_data;
              end
              default: begin
                wr_en = 1'b1;
                index_next = index_reg + INDEX_STEP;
              end
            endcase
          end
        end
        phase_ack_out: begin
          if (scl_fall) begin
            count_next = 4'h0;
            oe_next = 1'b0;
            phase_next = phase_rx;
            if (read_mode_reg) begin
              if (role_reg == role_count) begin
                tx_byte = 8'h00;
                tx_byte[READ_LENGTH_LSB +: READ_LENGTH_WIDTH] = read_length;
                role_next = role_data;
              end else begin
                index_next = index_reg + INDEX_STEP;
              end
              shift_next = tx_byte;
              oe_next = ~tx_byte[7];
              phase_next = phase_tx;
            end
          end
        end
        phase_tx: begin
          if (scl_fall) begin
            if (count_reg == LAST_TX_BIT) begin
              oe_next = 1'b0;
              phase_next = phase_ack_in;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
              count_next = count_reg + 4'h1;
            end
          end
        end
        phase_ack_in: begin
          if (scl_rise) begin
            acked_next = ~sda_sync_reg;
          end else if (scl_fall) begin
            count_next = 4'h0;
            if (acked_reg) begin
              shift_next = rd_data;
              oe_next = ~rd_data[7];
              index_next = index_reg + INDEX_STEP;
              phase_next = phase_tx;
            end else begin
              phase_next = phase_idle;
            end
          end
        end
        default: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= phase_idle;
      role_reg <= role_addr;
      shift_reg <= 8'h00;
      index_reg <= 8'h00;
      count_reg <= 4'h0;
      read_mode_reg <= 1'b0;
      acked_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      role_reg <= role_next;
      shift_reg <= shift_next;
      index_reg <= index_next;
      count_reg <= count_next;
      read_mode_reg <= read_mode_next;
      acked_reg <= acked_next;
      oe_reg <= oe_next;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // open drain: the data pin is only ever pulled low
  logic sda_out_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = oe_reg;

endmodule

// ### tb/smbus_id_regs_assertions.sv
// ------------------------------
// pin level checks
// ------------------------------
module smbus_id_regs_assertions (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [4:0] read_length
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // length register moves only in the clock low phase, together with an ack
  len_reset_a: assert property ($rose(rst_b) |-> read_length == 5'h08)
    else $error("length not eight after reset");
  len_scl_a: assert property (!$stable(read_length) |-> !scl_in)
    else $error("length moved with scl high");
  len_ack_a: assert property (!$stable(read_length) |-> ##[0:2] sda_oe)
    else $error("length write not acknowledged");
  // data moves only while scl is low, so no false start or stop is made
  oe_scl_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed with scl high");
  oe_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*4])
    else $error("sda drive too short");
  start_quiet_a: assert property (scl_in && $fell(sda_in) |-> !sda_oe [*8])
    else $error("sda driven right after start");
  out_low_a: assert property (sda_out == 1'b0)
    else $error("sda driven high");
endmodule

bind smbus_id_regs smbus_id_regs_assertions chk (.mclk(mclk), .rst_b(rst_b),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .read_length(read_length));

// ### tb/smbus_host_model.sv
// ------------------------------
// bus host: open drain, pull-up on sda
// ------------------------------
module smbus_host_model (
  input wire logic mclk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 4; // quarter bit in mclk; low phase must stay above 6 mclk
  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one bit: data set while scl low, sampled mid high; 1 means released
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    tick(half);
    scl <= 1'b1;
    tick(half);
    r = sda_wire;
    tick(half);
    scl <= 1'b0;
    tick(half);
  endtask
  // start also serves as repeated start from a low clock
  task automatic start();
    sda_pull <= 1'b0;
    tick(half);
    scl <= 1'b1;
    tick(half);
    sda_pull <= 1'b1;
    tick(half);
    scl <= 1'b0;
    tick(half);
  endtask
  task automatic stop();
    sda_pull <= 1'b1;
    tick(half);
    scl <= 1'b1;
    tick(half);
    sda_pull <= 1'b0;
    tick(half);
  endtask
  // byte msb first, then the ninth bit: ack_bit 0 acks, 1 releases
  task automatic xfer(input logic [7:0] tx, input logic ack_bit,
                      output logic [7:0] rx, output logic ack_seen);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ack_bit, ack_seen);
  endtask
endmodule

// ### tb/smbus_id_regs_tb.sv
module smbus_id_regs_tb
  import smbus_id_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // bench set-up
  // ------------------------------
  localparam logic [6:0] ADDR = 7'h50;
  localparam logic [3:0] REV = 4'h5; // arbitrary value
  localparam logic [3:0] MAKER = 4'hc; // arbitrary value
  localparam logic [1:0] CLASS = 2'h3; // arbitrary value
  localparam logic [5:0] PART = 6'h13; // arbitrary value
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  logic [4:0] read_length;
  logic sda_wire;
  logic [7:0] rx;
  logic a;
  logic [7:0] ro[3] = '{IDX_RESERVED, IDX_REV_VENDOR, IDX_DEVICE_TYPE};
  logic [7:0] lens[3] = '{8'hff, 8'h00, 8'h10};
  int fails = 0;
  int samples_checked = 0;
  // pull-up wins unless someone pulls low
  assign sda_wire = (sda_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  smbus_id_regs #(.SLAVE_ADDR(ADDR), .REVISION_CODE(REV), .MAKER_CODE(MAKER),
    .PART_CLASS(CLASS), .PART_CODE(PART)) uut (.mclk(mclk), .rst_b(rst_b),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .read_length(read_length));
  smbus_host_model host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl),
    .sda_pull(sda_pull));
  // 125 MHz
  initial begin
    forever #4 mclk = ~mclk;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // host sends a byte and expects the device to ack it
  task automatic send(input logic [7:0] b);
    logic [7:0] r;
    logic k;
    host.xfer(b, 1'b1, r, k);
    chk_ack(k, 1'b0);
  endtask
  // block write: address, index, count, then data bytes at rising indices
  task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
    host.start();
    send({ADDR, 1'b0});
    send(idx);
    send(8'(d.size()));
    foreach (d[i]) send(d[i]);
    host.stop();
  endtask
  // indexed block read; exp holds the count byte first, last byte is nacked
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp[$]);
    logic [7:0] r;
    logic k;
    host.start();
    send({ADDR, 1'b0});
    send(idx);
    host.start();
    send({ADDR, 1'b1});
    foreach (exp[i]) begin
      host.xfer(8'hff, i == exp.size() - 1, r, k);
      chk_byte(r, exp[i]);
    end
    host.stop();
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_byte({3'h0, read_length}, 8'h08);
    // byte 8 past the window reads zero
    rd(IDX_RESERVED, '{8'h08, 8'hff, {REV, MAKER}, {CLASS, PART}, 8'h08, 8'h00});
    $display("test defaults done");
    // slow host, writes to fixed bytes are acked and dropped
    host.half = 8;
    foreach (ro[i]) wr(ro[i], '{8'h00});
    host.half = 4;
    rd(IDX_RESERVED, '{8'h08, 8'hff, {REV, MAKER}, {CLASS, PART}});
    $display("test fixed bytes done");
    // top three bits are reserved and read back zero
    foreach (lens[i]) begin
      wr(IDX_READ_LENGTH, '{lens[i]});
      chk_byte({3'h0, read_length}, lens[i] & 8'h1f);
      rd(IDX_READ_LENGTH, '{lens[i] & 8'h1f, lens[i] & 8'h1f});
    end
    // two data bytes from index 6: the first is dropped, the second lands on the length
    wr(IDX_DEVICE_TYPE, '{8'h00, 8'h0c});
    chk_byte({3'h0, read_length}, 8'h0c);
    rd(IDX_DEVICE_TYPE, '{8'h0c, {CLASS, PART}, 8'h0c});
    $display("test read length done");
    // a foreign address is not acknowledged
    host.start();
    host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, rx, a);
    chk_ack(a, 1'b1);
    host.stop();
    $display("test address done");
    // reset in mid-run brings the length back to eight
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_byte({3'h0, read_length}, 8'h08);
    rd(IDX_READ_LENGTH, '{8'h08, 8'h08});
    $display("test reset done");
    complete_run();
  end
  // about 13k mclk expected; cut a hang well beyond that
  initial begin
    #500us;
    fails++;
    complete_run();
  end
endmodule
